// *** adc_status_mode_pkg.sv ***
package adc_status_mode_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 16;
  localparam int unsigned NUM_CH = 6;

  // Printed register indices; the byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_IDENT  = 12'h000;
  localparam logic [ADDR_W-1:0] IDX_STATUS = 12'h001;
  localparam logic [ADDR_W-1:0] IDX_MODE   = 12'h002;
  localparam int unsigned       IDX_SHIFT  = 2;

  localparam logic [3:0]  CHANNEL_COUNT = 4'h6;
  localparam logic [15:0] STATUS_RESET  = 16'h0500;
  localparam logic [15:0] MODE_RESET    = 16'h0510;

  // Bit positions of the status and mode words; lock and resync are status only, timeout is mode only
  localparam int unsigned BIT_LOCK     = 15;
  localparam int unsigned BIT_RESYNC   = 14;
  localparam int unsigned BIT_MAP_CRC  = 13;
  localparam int unsigned BIT_LINK_CRC = 12;
  localparam int unsigned BIT_POLY     = 11;
  localparam int unsigned BIT_RST      = 10;
  localparam int unsigned BIT_WLEN_HI  = 9;
  localparam int unsigned BIT_WLEN_LO  = 8;
  localparam int unsigned BIT_TIMEOUT  = 4;

  // Mode bits that hold state; 15:14 always read zero
  localparam logic [15:0] MODE_STORE_MASK = 16'h3FFF;

  // Word length encodings
  localparam logic [1:0] WLEN_16      = 2'h0;
  localparam logic [1:0] WLEN_24      = 2'h1;
  localparam logic [1:0] WLEN_32_ZERO = 2'h2;
  localparam logic [1:0] WLEN_32_SIGN = 2'h3;

  typedef struct packed {
    logic              link_locked;
    logic              resync_pulse;
    logic              link_crc_error_pulse;
    logic [15:0]       map_crc_value;
    logic [NUM_CH-1:0] ch_new_data;
  } core_events_t;

  typedef struct packed {
    logic       map_crc_enable;
    logic       link_crc_enable;
    logic       crc_poly_ansi;
    logic [1:0] output_word_length;
    logic       link_timeout_enable;
    logic [3:0] ready_pin_ctrl;
  } mode_cfg_t;

endpackage

// *** adc_status_mode_registers.sv ***
`timescale 1ns/100ps
module adc_status_mode_registers #(
  parameter logic [3:0] ID_UPPER_NIBBLE = 4'hA,  // Arbitrary value
  parameter logic [7:0] ID_REVISION     = 8'h00  // Arbitrary value
) (
  input  wire logic                                      pclk,
  input  wire logic                                      presetn,
  input  wire logic                                      psel,
  input  wire logic                                      penable,
  input  wire logic                                      pwrite,
  input  wire logic [adc_status_mode_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [adc_status_mode_pkg::DATA_W-1:0]    pwdata,
  output logic      [adc_status_mode_pkg::DATA_W-1:0]    prdata,
  output logic                                           pready,
  output logic                                           pslverr,
  input  wire adc_status_mode_pkg::core_events_t         core_events,
  output adc_status_mode_pkg::mode_cfg_t                 mode_cfg
);

  logic [15:0]                              mode_q;
  logic [15:0]                              mode_d;
  logic                                     locked_q;
  logic                                     resync_q;
  logic                                     map_crc_q;
  logic                                     link_crc_q;
  logic [adc_status_mode_pkg::NUM_CH-1:0]   new_data_q;
  logic [15:0]                              crc_prev_q;
  logic                                     pready_q;
  logic                                     pslverr_q;
  logic [adc_status_mode_pkg::DATA_W-1:0]   prdata_q;

  wire logic [15:0] ident_word;
  wire logic [15:0] status_word;
  wire logic [15:0] mode_word;
  wire logic [15:0] read_word;
  wire logic [adc_status_mode_pkg::ADDR_W-1:0] reg_idx;
  wire logic        idx_ok;
  wire logic        hit_ident;
  wire logic        hit_status;
  wire logic        hit_mode;
  wire logic        mapped;
  wire logic        setup_phase;
  wire logic        done;
  wire logic        mode_wr;
  wire logic        status_rd;
  wire logic        set_resync;
  wire logic        set_map_crc;
  wire logic        set_link_crc;
  wire logic        clr_resync;
  wire logic        clr_map_crc;
  wire logic        clr_link_crc;

  assign reg_idx     = paddr >> adc_status_mode_pkg::IDX_SHIFT;
  assign idx_ok      = (paddr[adc_status_mode_pkg::IDX_SHIFT-1:0] == '0);
  assign hit_ident   = idx_ok && (reg_idx == adc_status_mode_pkg::IDX_IDENT);
  assign hit_status  = idx_ok && (reg_idx == adc_status_mode_pkg::IDX_STATUS);
  assign hit_mode    = idx_ok && (reg_idx == adc_status_mode_pkg::IDX_MODE);
  assign mapped      = hit_ident || hit_status || hit_mode;
  assign setup_phase = psel && !penable;
  assign done        = psel && penable && pready_q;
  // Writes to read-only words are refused with an error
  assign mode_wr     = done && pwrite && hit_mode;
  assign status_rd   = done && !pwrite && hit_status;

  assign ident_word  = {ID_UPPER_NIBBLE, adc_status_mode_pkg::CHANNEL_COUNT, ID_REVISION};
  assign mode_word   = mode_q & adc_status_mode_pkg::MODE_STORE_MASK;
  // Polynomial, reset flag and word length mirror the mode word directly
  assign status_word = {locked_q, resync_q, map_crc_q, link_crc_q,
                        mode_q[adc_status_mode_pkg::BIT_POLY],
                        mode_q[adc_status_mode_pkg::BIT_RST],
                        mode_q[adc_status_mode_pkg::BIT_WLEN_HI:adc_status_mode_pkg::BIT_WLEN_LO],
                        2'h0, new_data_q};
  assign read_word   = hit_ident  ? ident_word  :
                       hit_status ? status_word :
                       hit_mode   ? mode_word   : 16'h0000;

  // Reserved bits 7:5 are kept as written; the host is expected to write zeros
  assign mode_d = (pwdata[15:0] & adc_status_mode_pkg::MODE_STORE_MASK);

  // Events that arrive while a status read completes stay set
  assign set_resync   = core_events.resync_pulse;
  assign set_map_crc  = mode_q[adc_status_mode_pkg::BIT_MAP_CRC] &&
                        (core_events.map_crc_value != crc_prev_q);
  assign set_link_crc = mode_q[adc_status_mode_pkg::BIT_LINK_CRC] &&
                        core_events.link_crc_error_pulse;
  // Only flags the host actually saw in the read are cleared
  assign clr_resync   = status_rd && prdata_q[adc_status_mode_pkg::BIT_RESYNC];
  assign clr_map_crc  = status_rd && prdata_q[adc_status_mode_pkg::BIT_MAP_CRC];
  assign clr_link_crc = status_rd && prdata_q[adc_status_mode_pkg::BIT_LINK_CRC];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= adc_status_mode_pkg::MODE_RESET;
    end else if (mode_wr) begin
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked_q   <= 1'b0;
      resync_q   <= 1'b0;
      map_crc_q  <= 1'b0;
      link_crc_q <= 1'b0;
      new_data_q <= '0;
      crc_prev_q <= 16'h0000;
    end else begin
      locked_q   <= core_events.link_locked;
      resync_q   <= set_resync || (resync_q && !clr_resync);
      map_crc_q  <= set_map_crc || (map_crc_q && !clr_map_crc);
      link_crc_q <= set_link_crc || (link_crc_q && !clr_link_crc);
      new_data_q <= core_events.ch_new_data;
      crc_prev_q <= core_events.map_crc_value;
    end
  end

  // No wait states: data and error are prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= setup_phase;
      pslverr_q <= setup_phase && (!mapped || (pwrite && !hit_mode));
      prdata_q  <= (setup_phase && !pwrite) ? {16'h0000, read_word} : '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_cfg <= '{map_crc_enable: 1'b0, link_crc_enable: 1'b0, crc_poly_ansi: 1'b0,
                    output_word_length: adc_status_mode_pkg::WLEN_24,
                    link_timeout_enable: 1'b1, ready_pin_ctrl: 4'h0};
    end else begin
      mode_cfg <= '{map_crc_enable: mode_q[adc_status_mode_pkg::BIT_MAP_CRC],
                    link_crc_enable: mode_q[adc_status_mode_pkg::BIT_LINK_CRC],
                    crc_poly_ansi: mode_q[adc_status_mode_pkg::BIT_POLY],
                    output_word_length: mode_q[adc_status_mode_pkg::BIT_WLEN_HI:adc_status_mode_pkg::BIT_WLEN_LO],
                    link_timeout_enable: mode_q[adc_status_mode_pkg::BIT_TIMEOUT],
                    ready_pin_ctrl: mode_q[3:0]};
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

endmodule

// *** adc_status_mode_properties.sv ***
`timescale 1ns/100ps
module adc_status_mode_properties (
  input wire logic                              pclk,
  input wire logic                              presetn,
  input wire logic                              psel,
  input wire logic                              penable,
  input wire logic                              pwrite,
  input wire logic [11:0]                       paddr,
  input wire logic [31:0]                       pwdata,
  input wire logic [31:0]                       prdata,
  input wire logic                              pready,
  input wire logic                              pslverr,
  input wire adc_status_mode_pkg::core_events_t core_events,
  input wire adc_status_mode_pkg::mode_cfg_t    mode_cfg
);
  wire rd_st = pready && !pwrite && paddr == 12'h004;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_next_a: assert property (psel && !penable |=> pready) else $error("no pready");
  ready_once_a: assert property (pready |=> !pready) else $error("long pready");
  ident_count_a: assert property (pready && !pwrite && paddr == 12'h000 |-> prdata[11:8] == 4'h6)
    else $error("bad ident");
  status_ro_a: assert property (pready && pwrite && paddr == 12'h004 |-> pslverr) else $error("status written");
  lock_view_a: assert property (core_events.link_locked [*3] ##1 rd_st |-> prdata[15]) else $error("no lock");
  mirror_a: assert property (rd_st |-> prdata[11:6] == {mode_cfg.crc_poly_ansi, prdata[10],
    mode_cfg.output_word_length, 2'b00}) else $error("status mirror");
  unmapped_a: assert property (pready && paddr > 12'h008 |-> pslverr && prdata == 32'h0) else $error("unmapped");
  mode_apply_a: assert property (pready && pwrite && paddr == 12'h008 |=> ##1
    mode_cfg.output_word_length == $past(pwdata[9:8], 2)) else $error("mode not applied");
  cover property (rd_st && prdata[14]);
  cover property (pready && pslverr);
  cover property (mode_cfg.crc_poly_ansi);
endmodule

// *** core_event_model.sv ***
`timescale 1ns/100ps
module core_event_model (
  input wire logic                          pclk,
  input wire logic                          presetn,
  input wire logic                          lock_in,
  input wire logic [5:0]                    data_in,
  input wire logic [2:0]                    ev_req,
  output adc_status_mode_pkg::core_events_t core_events
);
  // Events leave a flop, as from the real core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_events <= '0;
    end else begin
      core_events <= {lock_in, ev_req[0], ev_req[1], core_events.map_crc_value + {15'h0000, ev_req[2]}, data_in};
    end
  end
endmodule

// *** adc_status_mode_registers_test.sv ***
`timescale 1ns/100ps
module adc_status_mode_registers_test;
  logic                               pclk, presetn, psel, penable, pwrite, lock_in, pready, pslverr, er;
  logic [11:0]                        paddr;
  logic [31:0]                        pwdata, prdata, rd;
  logic [5:0]                         data_in;
  logic [2:0]                         ev_req;
  int                                 bad_count, tests_run, cycles;
  adc_status_mode_pkg::core_events_t  core_events;
  adc_status_mode_pkg::mode_cfg_t     mode_cfg;
  core_event_model core_event_model_inst (.pclk(pclk), .presetn(presetn), .lock_in(lock_in), .data_in(data_in),
    .ev_req(ev_req), .core_events(core_events));
  adc_status_mode_registers adc_status_mode_registers_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_events(core_events), .mode_cfg(mode_cfg));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      bad_count++;
      $display("unexpected pready expected 1 seen %b", pready);
    end
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd & m);
    chk("read error", {31'h0, ee}, {31'h0, er});
  endtask
  task automatic wc(input logic [11:0] a, input logic [31:0] d, input logic ee);
    apb(1'b1, a, d);
    chk("write error", {31'h0, ee}, {31'h0, er});
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      complete_run;
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, lock_in, paddr, pwdata, data_in, ev_req} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    chk("cfg", 32'h030, {22'h0, mode_cfg});
    rc("ident", 12'h000, 32'hFFFF0F00, 32'h00000600, 1'b0);
    rc("status", 12'h004, 32'hFFFFFFFF, 32'h00000500, 1'b0);
    rc("mode", 12'h008, 32'hFFFFFFFF, 32'h00000510, 1'b0);
    for (int w = 0; w < 4; w++) begin
      wc(12'h008, 32'h0000381F | (32'(w) << 8), 1'b0);
      rc("length", 12'h004, 32'hFFFFFFFF, 32'h00000800 | (32'(w) << 8), 1'b0);
    end
    rc("mode", 12'h008, 32'hFFFFFFFF, 32'h00003B1F, 1'b0);
    chk("cfg", 32'h3FF, {22'h0, mode_cfg});
    {lock_in, data_in, ev_req} <= {1'b1, 6'h2A, 3'h7};
    @(posedge pclk);
    ev_req <= 3'h0;
    repeat (4) @(posedge pclk);
    rc("events", 12'h004, 32'hFFFFFFFF, 32'h0000FB2A, 1'b0);
    rc("sticky", 12'h004, 32'hFFFFFFFF, 32'h00008B2A, 1'b0);
    wc(12'h000, 32'h0000FFFF, 1'b1);
    wc(12'h004, 32'h0000FFFF, 1'b1);
    rc("unmapped", 12'h00C, 32'hFFFFFFFF, 32'h0, 1'b1);
    wc(12'h008, 32'h00000410, 1'b0);
    {lock_in, data_in} <= 7'h00;
    rc("reset flag", 12'h004, 32'h00000F00, 32'h00000400, 1'b0);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rc("status", 12'h004, 32'hFFFFFFFF, 32'h00000500, 1'b0);
    rc("mode", 12'h008, 32'hFFFFFFFF, 32'h00000510, 1'b0);
    complete_run;
  end
endmodule
bind adc_status_mode_registers adc_status_mode_properties adc_status_mode_properties_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_events(core_events), .mode_cfg(mode_cfg));
